// [verilog/sradc_serial_if.sv]
// Conversion control and serial output of a 10-bit successive-approximation converter
//
// Behaviour
// - Power-down input low enters shutdown and stops converting.
// - Only normal and shutdown modes; power-down high gives normal operation.
// - In normal mode each select falling edge starts a new conversion.
// - Serial output is high impedance whenever select is high.
// - Serial output changes on rising serial clock edges, and clears to low when select rises.
// - Conversion advances on the master's clock, at most 6.4 or 4.8 MHz.
// - Each conversion yields a 10-bit result from the held sample.
// - Result is sent as unsigned straight binary in one serial stream.
// - Stream opens with three zeros, then result bits MSB first.
// - Select falling edge stops acquisition and freezes the sample.
// - At conversion end the front end returns to tracking the input.
// - Conversion time equals serial clock cycles used times clock period.
// - At select fall the output drives low until result bits begin.
// - Third rising edge after select falls presents the MSB.
// - Two sub-bits follow the LSB; further clocks give zeros harmlessly.
`timescale 1ns/10ps
`include "sradc_defs.svh"

module sradc_serial_if
   import sradc_pkg::*;
#(
   parameter bit FAST_VARIANT = 1'b1
) (
   input  wire logic                    ref_clk_i,
   input  wire logic                    rstn_i,
   input  wire logic                    sclk_i,
   input  wire logic                    cs_n_i,
   input  wire logic                    power_down_n_i,
   input  wire logic [`SRADC_SMP_W-1:0] analog_in_i,
   input  wire logic                    analog_in_valid_i,
   output logic                        analog_in_ready_o,
   output logic                        dout_o,
   output logic                        dout_oe_o,
   output logic                        tracking_o,
   output logic                        shutdown_o,
   output logic                        acq_done_o
);

   // Acquisition wait in system clock cycles, rounded up
   localparam int ACQ_NS  = FAST_VARIANT ? `SRADC_ACQ_NS_FAST : `SRADC_ACQ_NS_SLOW;
   localparam int ACQ_CYC = `SRADC_ACQ_CYC(ACQ_NS);
   localparam logic [6:0] ACQ_CYC_W = 7'(ACQ_CYC);
   // Shortest legal link clock period, for reference by users of the block
   localparam int SCLK_KHZ = FAST_VARIANT ? `SRADC_SCLK_MAX_KHZ_FAST
                                          : `SRADC_SCLK_MAX_KHZ_SLOW;
   localparam int SCLK_MIN_NS = `SRADC_SCLK_MIN_NS(SCLK_KHZ);

   // ---------------- System clock domain ----------------
   logic                    cs_s1_r;
   logic                    cs_s2_r;
   logic                    cs_s3_r;
   logic                    pdn_s1_r;
   logic                    pdn_s2_r;
   logic                    done_s1_r;
   logic                    done_s2_r;
   sradc_th_state_t         state_r;
   sradc_th_state_t         state_nxt;
   logic [`SRADC_SMP_W-1:0] held_r;
   logic                    smp_loaded_r;
   logic                    held_valid_r;
   logic                    dout_oe_r;
   logic                    tracking_r;
   logic                    shutdown_r;
   logic [6:0]              acq_cnt_r;
   logic                    acq_done_r;
   logic                    cs_fall;
   logic [`SRADC_SMP_W-1:0] buf_data;
   logic                    buf_valid;
   logic                    buf_ready;

   // ---------------- Link clock domain ----------------
   logic                    link_rst_n;
   logic [`SRADC_CNT_W-1:0] edge_cnt_r;
   logic [`SRADC_CNT_W-1:0] edge_cnt_nxt;
   logic                    valid_s1_r;
   logic                    valid_s2_r;
   logic [`SRADC_SMP_W-1:0] approx_r;
   logic                    dout_r;
   logic                    done_r;
   logic [`SRADC_SMP_W-1:0] trial;
   logic                    in_window;
   logic                    bit_nxt;

   // Weight of the bit decided at a given edge count
   function automatic logic [`SRADC_SMP_W-1:0] sradc_trial_mask(
      input logic [`SRADC_CNT_W-1:0] cnt);
      logic [`SRADC_CNT_W-1:0] sh;
      sh = `SRADC_LAST_EDGE - cnt;
      sradc_trial_mask = {{(`SRADC_SMP_W-1){1'b0}}, 1'b1} << sh;
   endfunction

   // Sample stream buffer; drained only while tracking
   sradc_buf2 #(
      .W     (`SRADC_SMP_W),
      .DEPTH (`SRADC_BUF_DEPTH)
   ) u_buf (
      .clk_i       (ref_clk_i),
      .rstn_i      (rstn_i),
      .in_data_i   (analog_in_i),
      .in_valid_i  (analog_in_valid_i),
      .in_ready_o  (analog_in_ready_o),
      .out_data_o  (buf_data),
      .out_valid_o (buf_valid),
      .out_ready_i (buf_ready)
   );

   assign buf_ready = (state_r == SRADC_ST_TRACK);

   // Pin synchronisers; select idles high, power-down idles low
   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cs_s1_r  <= 1'b1;
         cs_s2_r  <= 1'b1;
         cs_s3_r  <= 1'b1;
         pdn_s1_r <= 1'b0;
         pdn_s2_r <= 1'b0;
      end else begin
         cs_s1_r  <= cs_n_i;
         cs_s2_r  <= cs_s1_r;
         cs_s3_r  <= cs_s2_r;
         pdn_s1_r <= power_down_n_i;
         pdn_s2_r <= pdn_s1_r;
      end
   end

   // Completion level from the link domain
   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         done_s1_r <= 1'b0;
         done_s2_r <= 1'b0;
      end else begin
         done_s1_r <= done_r;
         done_s2_r <= done_s1_r;
      end
   end

   assign cs_fall = cs_s3_r & ~cs_s2_r;

   // Track/hold sequencing
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         SRADC_ST_POWER_DOWN_N: begin
            if (pdn_s2_r) begin
               state_nxt = SRADC_ST_TRACK;
            end
         end
         SRADC_ST_TRACK: begin
            if (!pdn_s2_r) begin
               state_nxt = SRADC_ST_POWER_DOWN_N;
            end else if (cs_fall) begin
               state_nxt = SRADC_ST_HOLD;
            end
         end
         SRADC_ST_HOLD: begin
            if (!pdn_s2_r) begin
               state_nxt = SRADC_ST_POWER_DOWN_N;
            end else if (done_s2_r || cs_s2_r) begin
               state_nxt = SRADC_ST_TRACK;
            end
         end
         default: begin
            state_nxt = SRADC_ST_POWER_DOWN_N;
         end
      endcase
   end

   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state_r <= SRADC_ST_POWER_DOWN_N;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Tracked sample follows the input, frozen outside tracking
   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         held_r       <= '0;
         smp_loaded_r <= 1'b0;
      end else if (state_r == SRADC_ST_POWER_DOWN_N) begin
         smp_loaded_r <= 1'b0;
      end else if (buf_ready && buf_valid) begin
         held_r       <= buf_data;
         smp_loaded_r <= 1'b1;
      end
   end

   // Conversion qualifier handed to the link domain
   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         held_valid_r <= 1'b0;
      end else begin
         held_valid_r <= (state_nxt == SRADC_ST_HOLD) & smp_loaded_r;
      end
   end

   // Output enable follows select; mode and tracking status
   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         dout_oe_r  <= 1'b0;
         tracking_r <= 1'b0;
         shutdown_r <= 1'b1;
      end else begin
         dout_oe_r  <= ~cs_s2_r;
         tracking_r <= (state_nxt == SRADC_ST_TRACK);
         shutdown_r <= (state_nxt == SRADC_ST_POWER_DOWN_N);
      end
   end

   // Acquisition timer; flags when a new sample has settled
   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         acq_cnt_r  <= '0;
         acq_done_r <= 1'b0;
      end else begin
         if ((state_r != SRADC_ST_TRACK) || (state_nxt != SRADC_ST_TRACK)) begin
            acq_cnt_r <= '0;
         end else if (acq_cnt_r != ACQ_CYC_W) begin
            acq_cnt_r <= acq_cnt_r + 7'd1;
         end
         acq_done_r <= (state_nxt == SRADC_ST_TRACK) && (acq_cnt_r == ACQ_CYC_W);
      end
   end

   assign dout_oe_o  = dout_oe_r;
   assign tracking_o = tracking_r;
   assign shutdown_o = shutdown_r;
   assign acq_done_o = acq_done_r;

   // ---------------- Link side, clocked by the master ----------------
   // Select high or system reset clears the frame
   assign link_rst_n = rstn_i & ~cs_n_i;

   // Saturating count of rising edges since select fell
   assign edge_cnt_nxt = (edge_cnt_r == `SRADC_CNT_SAT) ? edge_cnt_r
                                                        : edge_cnt_r + 1'b1;

   always_ff @(posedge sclk_i or negedge link_rst_n) begin
      if (!link_rst_n) begin
         edge_cnt_r <= '0;
      end else begin
         edge_cnt_r <= edge_cnt_nxt;
      end
   end

   // Conversion qualifier brought over by two flip-flops
   always_ff @(posedge sclk_i or negedge link_rst_n) begin
      if (!link_rst_n) begin
         valid_s1_r <= 1'b0;
         valid_s2_r <= 1'b0;
      end else begin
         valid_s1_r <= held_valid_r;
         valid_s2_r <= valid_s1_r;
      end
   end

   // One approximation step per edge inside the result window
   assign in_window = (edge_cnt_nxt >= `SRADC_MSB_EDGE) &&
                      (edge_cnt_nxt <= `SRADC_LAST_EDGE);
   assign trial     = approx_r | sradc_trial_mask(edge_cnt_nxt);
   assign bit_nxt   = valid_s2_r && in_window && (held_r >= trial);

   always_ff @(posedge sclk_i or negedge link_rst_n) begin
      if (!link_rst_n) begin
         approx_r <= '0;
         dout_r   <= 1'b0;
         done_r   <= 1'b0;
      end else begin
         if (bit_nxt) begin
            approx_r <= trial;
         end
         dout_r <= bit_nxt;
         done_r <= done_r | (edge_cnt_nxt == `SRADC_LAST_EDGE);
      end
   end

   assign dout_o = dout_r;

   // ---------------- Checks ----------------
   sequence s_cs_fall;
      cs_s3_r && !cs_s2_r;
   endsequence

   sequence s_hold_then_done;
      (state_r == SRADC_ST_HOLD) && done_s2_r && pdn_s2_r;
   endsequence

   property p_oe_off;
      @(posedge ref_clk_i) disable iff (!rstn_i)
         cs_s2_r |=> !dout_oe_o;
   endproperty
   a_oe_off: assert property (p_oe_off) else $error("output enabled while select high");

   property p_oe_on;
      @(posedge ref_clk_i) disable iff (!rstn_i)
         s_cs_fall |=> dout_oe_o && !dout_o;
   endproperty
   a_oe_on: assert property (p_oe_on) else $error("output not driven low at select fall");

   property p_start;
      @(posedge ref_clk_i) disable iff (!rstn_i)
         s_cs_fall ##0 (state_r == SRADC_ST_TRACK) && pdn_s2_r
         |=> (state_r == SRADC_ST_HOLD) && !tracking_o;
   endproperty
   a_start: assert property (p_start) else $error("select fall did not start hold");

   property p_freeze;
      @(posedge ref_clk_i) disable iff (!rstn_i)
         (state_r == SRADC_ST_HOLD) |=> (state_r != SRADC_ST_HOLD) || $stable(held_r);
   endproperty
   a_freeze: assert property (p_freeze) else $error("held sample moved during hold");

   property p_power_down_n;
      @(posedge ref_clk_i) disable iff (!rstn_i)
         !pdn_s2_r |=> shutdown_o && !held_valid_r ##1 shutdown_o || pdn_s2_r;
   endproperty
   a_power_down_n: assert property (p_power_down_n) else $error("shutdown not entered");

   property p_normal;
      @(posedge ref_clk_i) disable iff (!rstn_i)
         (state_r == SRADC_ST_POWER_DOWN_N) && pdn_s2_r |=> !shutdown_o && tracking_o;
   endproperty
   a_normal: assert property (p_normal) else $error("normal mode not entered");

   property p_track_back;
      @(posedge ref_clk_i) disable iff (!rstn_i)
         s_hold_then_done |=> tracking_o && (state_r == SRADC_ST_TRACK);
   endproperty
   a_track_back: assert property (p_track_back) else $error("tracking not resumed");

   property p_lead_zero;
      @(posedge sclk_i) disable iff (!link_rst_n)
         (edge_cnt_r < `SRADC_MSB_EDGE) |-> !dout_o;
   endproperty
   a_lead_zero: assert property (p_lead_zero) else $error("leading bit not zero");

   property p_msb;
      @(posedge sclk_i) disable iff (!link_rst_n)
         (edge_cnt_r == `SRADC_MSB_EDGE) |-> (dout_o == ($past(valid_s2_r) && held_r[11]));
   endproperty
   a_msb: assert property (p_msb) else $error("third edge did not show the MSB");

   property p_bits;
      @(posedge sclk_i) disable iff (!link_rst_n)
         (edge_cnt_r >= `SRADC_MSB_EDGE) && (edge_cnt_r <= `SRADC_LAST_EDGE)
         && $past(valid_s2_r) |-> (dout_o == |($past(held_r) & sradc_trial_mask(edge_cnt_r)));
   endproperty
   a_bits: assert property (p_bits) else $error("serial bit differs from sample");

   property p_trail;
      @(posedge sclk_i) disable iff (!link_rst_n)
         (edge_cnt_r == `SRADC_CNT_SAT) |-> !dout_o && done_r;
   endproperty
   a_trail: assert property (p_trail) else $error("trailing bit not zero");

   property p_done;
      @(posedge sclk_i) disable iff (!link_rst_n)
         (edge_cnt_r == `SRADC_LAST_EDGE) |-> done_r ##1 done_r;
   endproperty
   a_done: assert property (p_done) else $error("completion not flagged");

endmodule

// [verilog/sradc_defs.svh]
// Constants of the serial successive-approximation converter interface
`ifndef SRADC_DEFS_SVH
`define SRADC_DEFS_SVH

// Result layout: ten result bits, two sub-bits, held sample twelve bits wide
`define SRADC_RES_W 10
`define SRADC_SUB_W 2
`define SRADC_SMP_W 12

// Serial clock edge counting
`define SRADC_CNT_W 5
`define SRADC_MSB_EDGE 5'd3
`define SRADC_LAST_EDGE 5'd14
`define SRADC_CNT_SAT 5'd15

// Timing: system clock rate, link clock ceilings, acquisition times
`define SRADC_REF_MHZ 100
`define SRADC_SCLK_MAX_KHZ_FAST 6400
`define SRADC_SCLK_MAX_KHZ_SLOW 4800
`define SRADC_ACQ_NS_FAST 468
`define SRADC_ACQ_NS_SLOW 625
`define SRADC_ACQ_CYC(ns) ((((ns) * `SRADC_REF_MHZ) + 999) / 1000)
`define SRADC_SCLK_MIN_NS(khz) ((1000000 + (khz) - 1) / (khz))

// Sample buffer depth
`define SRADC_BUF_DEPTH 2

`endif

// [verilog/sradc_pkg.sv]
// Types shared by the serial converter interface
package sradc_pkg;

   // Track/hold state of the sampling front end
   typedef enum logic [1:0] {
      SRADC_ST_POWER_DOWN_N,
      SRADC_ST_TRACK,
      SRADC_ST_HOLD
   } sradc_th_state_t;

endpackage

// [verilog/sradc_buf2.sv]
// Two-entry sample buffer with valid/ready on both sides
`timescale 1ns/10ps
`include "sradc_defs.svh"

module sradc_buf2 #(
   parameter int W     = `SRADC_SMP_W,
   parameter int DEPTH = `SRADC_BUF_DEPTH
) (
   input  wire logic         clk_i,
   input  wire logic         rstn_i,
   input  wire logic [W-1:0] in_data_i,
   input  wire logic         in_valid_i,
   output logic             in_ready_o,
   output logic [W-1:0]     out_data_o,
   output logic             out_valid_o,
   input  wire logic         out_ready_i
);

   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [PW-1:0] LAST_IDX = PW'(DEPTH - 1);
   localparam logic [PW:0]   FULL_CNT = (PW + 1)'(DEPTH);

   logic [W-1:0]  mem_r [0:DEPTH-1];
   logic [PW-1:0] wr_ptr_r;
   logic [PW-1:0] rd_ptr_r;
   logic [PW:0]   cnt_r;
   logic [PW:0]   cnt_nxt;
   logic          in_ready_r;
   logic          push;
   logic          pop;

   // Pointer advance with wrap
   function automatic logic [PW-1:0] buf_next_idx(input logic [PW-1:0] idx);
      buf_next_idx = (idx == LAST_IDX) ? '0 : idx + 1'b1;
   endfunction

   // Handshakes on both sides
   assign push        = in_valid_i & in_ready_r;
   assign pop         = out_valid_o & out_ready_i;
   assign out_valid_o = (cnt_r != '0);
   assign out_data_o  = mem_r[rd_ptr_r];
   assign in_ready_o  = in_ready_r;

   // Occupancy after this cycle
   always_comb begin
      cnt_nxt = cnt_r;
      if (push && !pop) begin
         cnt_nxt = cnt_r + 1'b1;
      end else if (pop && !push) begin
         cnt_nxt = cnt_r - 1'b1;
      end
   end

   // Storage write
   always_ff @(posedge clk_i) begin
      if (push) begin
         mem_r[wr_ptr_r] <= in_data_i;
      end
   end

   // Pointers, count and registered ready
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         wr_ptr_r   <= '0;
         rd_ptr_r   <= '0;
         cnt_r      <= '0;
         in_ready_r <= 1'b0;
      end else begin
         if (push) begin
            wr_ptr_r <= buf_next_idx(wr_ptr_r);
         end
         if (pop) begin
            rd_ptr_r <= buf_next_idx(rd_ptr_r);
         end
         cnt_r      <= cnt_nxt;
         in_ready_r <= (cnt_nxt != FULL_CNT);
      end
   end

endmodule

// [dv/sradc_master_model.sv]
// Serial clock master model: frames conversions and collects the output bit stream
`timescale 1ns/10ps

module sradc_master_model #(
   parameter int HALF_NS  = 32,
   parameter int SETUP_NS = 50,
   parameter int GAP_NS   = 700
) (
   output logic      sclk_o,
   output logic      cs_n_o,
   input  wire logic dout_i,
   input  wire logic dout_oe_i
);

   // Clock stands low and select high outside frames
   initial begin
      sclk_o = 1'b0;
      cs_n_o = 1'b1;
   end

   // One frame of n clocks; bits taken late in the high phase, rechecked before the next rise
   task automatic frame(input int n, output logic [23:0] word, output logic [1:0] lead,
                        output int unstable);
      logic mid;
      word     = '0;
      unstable = 0;
      cs_n_o   = 1'b0;                     // Fresh falling edge per frame
      #SETUP_NS;
      lead = {dout_oe_i, dout_i};
      for (int i = 0; i < n; i++) begin    // Conversion paced by our clock
         sclk_o = 1'b1;
         #HALF_NS;
         mid    = dout_i;
         sclk_o = 1'b0;
         #(HALF_NS - 1);
         if (dout_i !== mid)
            unstable++;
         word = {word[22:0], mid};
         #1;
      end
      cs_n_o = 1'b1;
      #GAP_NS;                             // Acquisition gap, also after an abort
   endtask

endmodule

// [dv/sradc_serial_if_tb.sv]
// Testbench of the serial converter interface driven by a clock master model
`timescale 1ns/10ps
`include "sradc_defs.svh"

module sradc_serial_if_tb;

   localparam int S_TRK = 0;
   localparam int S_ACQ = 1;
   localparam int S_SHD = 2;
   localparam int S_NRM = 3;
   localparam int S_OFF = 4;

   logic                    ref_clk_i;
   logic                    rstn_i;
   logic                    power_down_n_i;
   logic [`SRADC_SMP_W-1:0] analog_in_i;
   logic                    analog_in_valid_i;
   logic                    analog_in_ready_o;
   logic                    dout_o;
   logic                    dout_oe_o;
   logic                    tracking_o;
   logic                    shutdown_o;
   logic                    acq_done_o;
   logic                    sclk;
   logic                    cs_n;
   logic                    last_r = 1'b0;
   logic                    dout_line;
   int                      err_total;
   int                      samples_checked;

   sradc_serial_if dut (
      .ref_clk_i         (ref_clk_i),
      .rstn_i            (rstn_i),
      .sclk_i            (sclk),
      .cs_n_i            (cs_n),
      .power_down_n_i    (power_down_n_i),
      .analog_in_i       (analog_in_i),
      .analog_in_valid_i (analog_in_valid_i),
      .analog_in_ready_o (analog_in_ready_o),
      .dout_o            (dout_o),
      .dout_oe_o         (dout_oe_o),
      .tracking_o        (tracking_o),
      .shutdown_o        (shutdown_o),
      .acq_done_o        (acq_done_o)
   );

   sradc_master_model master (
      .sclk_o    (sclk),
      .cs_n_o    (cs_n),
      .dout_i    (dout_line),
      .dout_oe_i (dout_oe_o)
   );

   // Released line shows the inverse of the last driven level
   always @(posedge ref_clk_i) if (dout_oe_o === 1'b1) last_r <= dout_o;
   assign dout_line = (dout_oe_o === 1'b1) ? dout_o : ~last_r;

   // System clock
   initial begin
      ref_clk_i = 1'b0;
      forever #5 ref_clk_i = ~ref_clk_i;
   end

   task automatic conclude();
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic chk(input string name, input logic [23:0] seen, input logic [23:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask

   function automatic logic sig(input int k);
      logic [4:0] v;
      v = {~dout_oe_o, ~shutdown_o, shutdown_o, acq_done_o, tracking_o};
      return v[k];
   endfunction

   // Bounded wait for a status level, judged at falling clock edges
   task automatic wait_sig(input int k, input string name);
      for (int i = 0; i < 300 && sig(k) !== 1'b1; i++)
         @(negedge ref_clk_i);
      chk(name, {23'h0, sig(k)}, 24'h1);
   endtask

   // Offer one sample word; taken at the rising edge that sees ready high
   task automatic push(input logic [11:0] s);
      int k;
      @(posedge ref_clk_i);
      analog_in_i       <= s;
      analog_in_valid_i <= 1'b1;
      for (k = 0; k < 300; k++) begin
         @(negedge ref_clk_i);
         if (analog_in_ready_o === 1'b1)
            break;
      end
      @(posedge ref_clk_i);
      analog_in_valid_i <= 1'b0;
      chk("push_taken", {23'h0, k < 300}, 24'h1);
   endtask

   // One frame of n clocks with expected sample s; optionally fill the buffer while held
   task automatic run(input int n, input logic [11:0] s, input bit fill);
      logic [23:0] word;
      logic [1:0]  lead;
      int          unstable;
      logic [23:0] exp;
      exp = {2'b00, s, 10'h000} >> (24 - n);
      fork
         master.frame(n, word, lead, unstable);
         begin
            #300;
            chk("tracking_held", {23'h0, tracking_o}, 24'h0);
            if (fill) begin
               push(12'h0f1);
               push(12'h5a6);
               @(negedge ref_clk_i);
               chk("ready_full", {23'h0, analog_in_ready_o}, 24'h0);
            end
         end
      join
      chk("stream", word, exp);
      chk("lead_low", {22'h0, lead}, 24'h2);
      chk("stable_low_phase", unstable[23:0], 24'h0);
      chk("released", {23'h0, dout_oe_o}, 24'h0);
   endtask

   // Boundary and patterned codes in back-to-back frames
   task automatic t_basic();
      logic [11:0] v [4] = '{12'hfff, 12'h000, 12'ha5c, 12'h3c3};
      foreach (v[i]) begin
         push(v[i]);
         wait_sig(S_ACQ, "acq_done");
         run(16, v[i], 1'b0);
      end
   endtask

   // Sample frozen while words arrive; buffer full, then drained to newest word
   task automatic t_hold_fill();
      push(12'h2b7);
      wait_sig(S_ACQ, "acq_done");
      run(16, 12'h2b7, 1'b1);
      wait_sig(S_TRK, "tracking_back");
      chk("ready_drained", {23'h0, analog_in_ready_o}, 24'h1);
      wait_sig(S_ACQ, "acq_done");
      run(16, 12'h5a6, 1'b0);
   endtask

   // Trailing zeros, then an abort followed by a full frame
   task automatic t_trailing_abort();
      run(20, 12'h5a6, 1'b0);
      run(8, 12'h5a6, 1'b0);
      wait_sig(S_ACQ, "acq_done");
      run(16, 12'h5a6, 1'b0);
   endtask

   // Shutdown gives zeros; normal mode converts again
   task automatic t_shutdown();
      @(posedge ref_clk_i);
      power_down_n_i <= 1'b0;
      wait_sig(S_SHD, "shutdown_on");
      chk("tracking_off", {23'h0, tracking_o}, 24'h0);
      run(16, 12'h000, 1'b0);
      @(posedge ref_clk_i);
      power_down_n_i <= 1'b1;
      wait_sig(S_NRM, "shutdown_off");
      wait_sig(S_TRK, "tracking_on");
      push(12'h1e4);
      wait_sig(S_ACQ, "acq_done");
      run(16, 12'h1e4, 1'b0);
   endtask

   // Watchdog well beyond the expected run time
   initial begin
      #200000;
      err_total++;
      conclude();
   end

   // Main sequence
   initial begin
      err_total         = 0;
      samples_checked   = 0;
      rstn_i            = 1'b0;
      power_down_n_i    = 1'b1;
      analog_in_i       = '0;
      analog_in_valid_i = 1'b0;
      repeat (12) @(posedge ref_clk_i);
      rstn_i <= 1'b1;
      wait_sig(S_NRM, "normal_after_reset");
      wait_sig(S_TRK, "tracking_after_reset");
      chk("idle_released", {23'h0, dout_oe_o}, 24'h0);
      t_basic();
      t_hold_fill();
      t_trailing_abort();
      t_shutdown();
      conclude();
   end

endmodule
